/* bsi_pkg.sv */
package bsi_pkg;

  // ==========================================================
  // register lengths
  localparam int BSR_LEN      = 163;
  localparam int IR_LEN       = 4;
  localparam int SER_CLK_CELL = 132;

  // ==========================================================
  // instruction codes
  localparam logic [IR_LEN-1:0] IR_EXTEST  = 4'h0;
  localparam logic [IR_LEN-1:0] IR_SAMPLE  = 4'h2;
  localparam logic [IR_LEN-1:0] IR_BYPASS  = 4'hf;
  localparam logic [IR_LEN-1:0] IR_OFF     = 4'h9;
  localparam logic [IR_LEN-1:0] IR_CLAMP   = 4'hc;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;

  // ==========================================================
  // direction-control cells of the boundary register
  localparam int N_CTL = 47;
  localparam int CTL_CELLS [N_CTL] = '{
    5, 32, 54, 56, 62, 64, 66, 68, 70, 72, 74, 76,
    78, 80, 82, 84, 86, 88, 90, 92, 94, 96, 101,
    107, 109, 111, 113, 115, 117, 119, 121, 123, 125,
    133, 137, 139, 141, 143, 145, 147, 149, 151, 153,
    155, 157, 159, 161};

  function automatic logic [BSR_LEN-1:0] ctl_mask();
    logic [BSR_LEN-1:0] m;
    m = '0;
    for (int k = 0; k < N_CTL; k++) begin
      m[CTL_CELLS[k]] = 1'h1;
    end
    return m;
  endfunction

  localparam logic [BSR_LEN-1:0] CTL_MASK = ctl_mask();

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    TAP_TLR    = 4'b1111,
    TAP_RTI    = 4'b1100,
    TAP_SEL_DR = 4'b0111,
    TAP_CAP_DR = 4'b0110,
    TAP_SH_DR  = 4'b0010,
    TAP_EX1_DR = 4'b0001,
    TAP_PA_DR  = 4'b0011,
    TAP_EX2_DR = 4'b0000,
    TAP_UPD_DR = 4'b0101,
    TAP_SEL_IR = 4'b0100,
    TAP_CAP_IR = 4'b1110,
    TAP_SH_IR  = 4'b1010,
    TAP_EX1_IR = 4'b1001,
    TAP_PA_IR  = 4'b1011,
    TAP_EX2_IR = 4'b1000,
    TAP_UPD_IR = 4'b1101
  } bsi_tap_state_t;

  typedef enum logic [2:0] {
    INS_EXTEST = 3'b000,
    INS_SAMPLE = 3'b001,
    INS_BYPASS = 3'b010,
    INS_OFF    = 3'b011,
    INS_CLAMP  = 3'b100
  } bsi_instr_t;

endpackage

/* bsi_scan_asserts.sv */
`timescale 1ns/100ps
module bsi_scan_asserts
  import bsi_pkg::*;
(
  input wire logic                        i_clk_sys,
  input wire logic                        i_resetn,
  input wire logic                        i_tck,
  input wire logic                        i_trst_n,
  input wire logic                        i_tms,
  input wire logic [bsi_pkg::BSR_LEN-1:0] i_core_val,
  input wire logic                        o_tdo,
  input wire logic                        o_tdo_oe,
  input wire logic [bsi_pkg::BSR_LEN-1:0] o_pin_val,
  input wire logic                        o_test_drive,
  input wire logic                        o_drv_off
);
  // ====
  // link side
  sequence trst_s;
    !i_trst_n ##1 !i_trst_n;
  endsequence
  sequence normal_s;
    !o_test_drive [*3];
  endsequence

  trst_quiet_a: assert property (@(posedge i_tck) trst_s |-> !o_tdo_oe)
    else $error("tdo driven during test reset");
  tms_exit_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    i_tms |=> !o_tdo_oe) else $error("tdo driven after tms high");
  oe_entry_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    $rose(o_tdo_oe) |-> !$past(i_tms)) else $error("shift entered with tms high");
  shift_hold_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    o_tdo_oe && !i_tms |=> o_tdo_oe) else $error("shift left with tms low");
  // tck stays at a level for longer than one system period
  tdo_fall_a: assert property (@(posedge i_clk_sys) disable iff (!i_trst_n)
    $changed(o_tdo) |-> !i_tck) else $error("tdo moved while tck high");
  // ====
  // system side
  sys_reset_a: assert property (@(posedge i_clk_sys) !i_resetn |=>
    !o_test_drive && !o_drv_off && o_pin_val == '0) else $error("outputs not cleared");
  off_excl_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_drv_off |-> !o_test_drive) else $error("outputs off while test driving");
  pin_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    normal_s |-> o_pin_val == $past(i_core_val)) else $error("pins left core values");
endmodule

bind bsi_scan_top bsi_scan_asserts u_chk (.i_clk_sys, .i_resetn, .i_tck, .i_trst_n,
  .i_tms, .i_core_val, .o_tdo, .o_tdo_oe, .o_pin_val, .o_test_drive, .o_drv_off);

/* bsi_scan_top.sv */
// Functional notes
// - four-bit instruction register, no parity, shifted TDI to TDO in IR shift
// - active instruction changes only in Update-IR, taking the shift stages, and in test-logic reset
// - decode 0000 extest, 0010 sample, 1111 bypass, 1001 off, 1100 clamp
// - test-logic reset forces the active instruction to bypass
// - Capture-IR loads 0001 into the instruction shift stages
// - extest puts the 163-cell boundary register between TDI and TDO
// - extest drives pins, captures inputs, sets directions and enables
// - sample captures pin and control values on rising TCK in Capture-DR
// - sample shifting leaves normal system operation untouched
// - sample preloads output cells so extest starts with known values
// - bypass puts a single-bit register between TDI and TDO
// - selected bypass register clears to zero in Capture-DR
// - clamp selects bypass while pins take the held boundary cells
// - outputs-off instruction turns every output driver off
// - cell 132 observes internal serial clock; crystal input has no cell
// - one direction cell governs several bidirectional cells after it
// - outputs-off instruction selects the single-bit bypass register
// - direction cells capture the value of the following cell
`timescale 1ns/100ps
module bsi_scan_top
  import bsi_pkg::*;
(
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_resetn,
  input  wire logic                          i_tck,
  input  wire logic                          i_trst_n,
  input  wire logic                          i_tms,
  input  wire logic                          i_tdi,
  output logic                               o_tdo,
  output logic                               o_tdo_oe,
  input  wire logic [bsi_pkg::BSR_LEN-1:0]   i_pin_in,
  input  wire logic                          i_ser_clk,
  input  wire logic [bsi_pkg::BSR_LEN-1:0]   i_core_val,
  output logic      [bsi_pkg::BSR_LEN-1:0]   o_pin_val,
  output logic                               o_test_drive,
  output logic                               o_drv_off
);
  import bsi_pkg::*;

  // ==========================================================
  // instruction decode
  function automatic bsi_instr_t decode(input logic [IR_LEN-1:0] code);
    bsi_instr_t ins;
    case (code)
      IR_EXTEST: ins = INS_EXTEST;
      IR_SAMPLE: ins = INS_SAMPLE;
      IR_BYPASS: ins = INS_BYPASS;
      IR_OFF:    ins = INS_OFF;
      IR_CLAMP:  ins = INS_CLAMP;
      default:   ins = INS_BYPASS;
    endcase
    return ins;
  endfunction

  // ==========================================================
  // controller
  bsi_tap_if tap ();

  bsi_tap_fsm u_fsm (
    .i_tck    (i_tck),
    .i_trst_n (i_trst_n),
    .i_tms    (i_tms),
    .tap      (tap)
  );

  // ==========================================================
  // test clock domain state
  typedef struct packed {
    logic [BSR_LEN-1:0] pin_s1;
    logic [BSR_LEN-1:0] pin_s2;
    logic               ser_s1;
    logic               ser_s2;
    logic [IR_LEN-1:0]  ir_sh;
    logic [IR_LEN-1:0]  ir;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_upd;
    logic               byp;
    logic               drive;
    logic               off;
    logic               upd_tgl;
  } bsi_tck_reg_t;

  localparam bsi_tck_reg_t TCK_RST = '{
    pin_s1:  '0,
    pin_s2:  '0,
    ser_s1:  1'h0,
    ser_s2:  1'h0,
    ir_sh:   IR_CAPTURE,
    ir:      IR_BYPASS,
    bsr_sh:  '0,
    bsr_upd: '0,
    byp:     1'h0,
    drive:   1'h0,
    off:     1'h0,
    upd_tgl: 1'h0
  };

  bsi_tck_reg_t t;
  bsi_tck_reg_t next_t;

  bsi_instr_t         cur_ins;
  bsi_instr_t         new_ins;
  logic               sel_bsr;
  logic [BSR_LEN-1:0] cap_vec;

  assign cur_ins = decode(t.ir);
  assign sel_bsr = (cur_ins == INS_EXTEST) || (cur_ins == INS_SAMPLE);

  // ==========================================================
  // capture values per cell
  for (genvar gi = 0; gi < BSR_LEN; gi++) begin : g_cap
    if (gi == SER_CLK_CELL) begin : g_ser
      // internal serial clock; the crystal input has no cell
      assign cap_vec[gi] = t.ser_s2;
    end else if ((gi < BSR_LEN - 1) && CTL_MASK[gi]) begin : g_ctl
      // direction cell sees the cell after it
      assign cap_vec[gi] = t.pin_s2[gi+1];
    end else begin : g_pin
      assign cap_vec[gi] = t.pin_s2[gi];
    end
  end

  always_comb begin
    next_t = t;

    // pins and serial clock come from other domains
    next_t.pin_s1 = i_pin_in;
    next_t.pin_s2 = t.pin_s1;
    next_t.ser_s1 = i_ser_clk;
    next_t.ser_s2 = t.ser_s1;

    // instruction shift stages
    if (tap.cap_ir) begin
      next_t.ir_sh = IR_CAPTURE;
    end else if (tap.sh_ir) begin
      next_t.ir_sh = {i_tdi, t.ir_sh[IR_LEN-1:1]};
    end

    // active instruction
    if (tap.tlr) begin
      next_t.ir = IR_BYPASS;
    end else if (tap.upd_ir) begin
      next_t.ir = t.ir_sh;
    end

    // data registers
    if (tap.cap_dr) begin
      if (sel_bsr) begin
        next_t.bsr_sh = cap_vec;
      end else begin
        next_t.byp = 1'h0;
      end
    end else if (tap.sh_dr) begin
      if (sel_bsr) begin
        next_t.bsr_sh = {i_tdi, t.bsr_sh[BSR_LEN-1:1]};
      end else begin
        next_t.byp = i_tdi;
      end
    end

    // update cells; under sample the pins stay with the core
    if (tap.upd_dr && sel_bsr) begin
      next_t.bsr_upd = t.bsr_sh;
      next_t.upd_tgl = ~t.upd_tgl;
    end

    // pin control flags follow the next instruction
    new_ins      = decode(next_t.ir);
    next_t.drive = (new_ins == INS_EXTEST) || (new_ins == INS_CLAMP);
    next_t.off   = (new_ins == INS_OFF);
  end

  always_ff @(posedge i_tck) begin
    if (!i_trst_n) begin
      t <= TCK_RST;
    end else begin
      t <= next_t;
    end
  end

  // ==========================================================
  // scan output on falling test clock
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bsi_out_reg_t;

  bsi_out_reg_t o;
  bsi_out_reg_t next_o;

  always_comb begin
    next_o        = o;
    next_o.tdo_oe = tap.sh_ir || tap.sh_dr;
    if (tap.sh_ir) begin
      next_o.tdo = t.ir_sh[0];
    end else if (sel_bsr) begin
      next_o.tdo = t.bsr_sh[0];
    end else begin
      next_o.tdo = t.byp;
    end
  end

  always_ff @(negedge i_tck) begin
    if (!i_trst_n) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  assign o_tdo    = o.tdo;
  assign o_tdo_oe = o.tdo_oe;

  // ==========================================================
  // system clock domain state
  typedef struct packed {
    logic               tgl_s1;
    logic               tgl_s2;
    logic               tgl_s3;
    logic [1:0]         flg_s1;
    logic [1:0]         flg_s2;
    logic [BSR_LEN-1:0] upd_copy;
    logic [BSR_LEN-1:0] pin_val;
    logic               test_drive;
    logic               drv_off;
  } bsi_sys_reg_t;

  bsi_sys_reg_t s;
  bsi_sys_reg_t next_s;

  always_comb begin
    next_s = s;

    // update toggle and pin flags cross into the system domain
    next_s.tgl_s1 = t.upd_tgl;
    next_s.tgl_s2 = s.tgl_s1;
    next_s.tgl_s3 = s.tgl_s2;
    next_s.flg_s1 = {t.drive, t.off};
    next_s.flg_s2 = s.flg_s1;

    // update cells are stable for many test clocks after a toggle
    if (s.tgl_s2 ^ s.tgl_s3) begin
      next_s.upd_copy = t.bsr_upd;
    end

    next_s.test_drive = s.flg_s2[1];
    next_s.drv_off    = s.flg_s2[0];
    if (s.flg_s2[1]) begin
      next_s.pin_val = s.upd_copy;
    end else begin
      next_s.pin_val = i_core_val;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_pin_val    = s.pin_val;
  assign o_test_drive = s.test_drive;
  assign o_drv_off    = s.drv_off;

endmodule

/* bsi_scan_top_tb_top.sv */
`timescale 1ns/100ps
module bsi_scan_top_tb_top;
  import bsi_pkg::*;
  logic               i_clk_sys, i_resetn, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic               ser_clk, test_drive, drv_off;
  logic [BSR_LEN-1:0] pin_in, core_val, pin_val, din, dout;
  int                 miscompares, check_count, cyc;
  logic [IR_LEN-1:0]  codes [6] = '{4'h0, 4'h2, 4'hf, 4'h9, 4'hc, 4'h5};

  bsi_scan_top i_dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_tck(tck),
    .i_trst_n(trst_n), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .i_pin_in(pin_in), .i_ser_clk(ser_clk), .i_core_val(core_val),
    .o_pin_val(pin_val), .o_test_drive(test_drive), .o_drv_off(drv_off));
  bsi_tester_model u_tester (.i_clk_sys(i_clk_sys), .i_tdo(tdo_oe ? tdo : ~tdo), .o_tck(tck),
    .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));

  // ====
  // helpers and model
  task automatic check(input string what, input logic [BSR_LEN-1:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [BSR_LEN-1:0] cap_model(input logic [BSR_LEN-1:0] p);
    logic [BSR_LEN-1:0] e;
    e = p;
    for (int k = 0; k < N_CTL; k++) e[CTL_CELLS[k]] = p[CTL_CELLS[k] + 1];
    e[SER_CLK_CELL] = ser_clk;
    return e;
  endfunction

  task automatic drive_sys();
    logic [191:0] a, b;
    a = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    b = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    @(posedge i_clk_sys);
    core_val <= a[BSR_LEN-1:0];
    pin_in   <= b[BSR_LEN-1:0];
    ser_clk  <= b[191];
    @(negedge i_clk_sys);
  endtask

  task automatic ld_ir(input logic [IR_LEN-1:0] code);
    u_tester.scan(1'h1, IR_LEN, {159'h0, code}, dout);
    check("ir capture", dout[3:0], IR_CAPTURE);
    repeat (12) @(negedge i_clk_sys);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    i_clk_sys = 1'h0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  // ====
  // main sequence
  initial begin
    {i_resetn, ser_clk, pin_in, core_val} = '0;
    {miscompares, check_count, cyc} = '0;
    void'($urandom(32'hdc1ef7e7));
    repeat (10) @(posedge i_clk_sys);
    i_resetn <= 1'h1;
    u_tester.treset();
    drive_sys();
    for (int c = 0; c < 6; c++) begin
      ld_ir(codes[c]);
      check("test_drive", test_drive, codes[c] inside {IR_EXTEST, IR_CLAMP});
      check("drv_off", drv_off, codes[c] == IR_OFF);
      if (!(codes[c] inside {IR_EXTEST, IR_SAMPLE})) begin
        u_tester.scan(1'h0, 2, core_val, dout);
        check("bypass path", dout[1:0], {core_val[0], 1'h0});
      end
    end
    ld_ir(IR_SAMPLE);
    drive_sys();
    din = core_val ^ pin_in;
    u_tester.scan(1'h0, BSR_LEN, din, dout);
    check("sample capture", dout, cap_model(pin_in));
    check("sample pins", pin_val, core_val);
    ld_ir(IR_EXTEST);
    check("preload pins", pin_val, din);
    din = ~din;
    u_tester.scan(1'h0, BSR_LEN, din, dout);
    check("extest capture", dout, cap_model(pin_in));
    repeat (12) @(negedge i_clk_sys);
    check("extest pins", pin_val, din);
    ld_ir(IR_CLAMP);
    u_tester.scan(1'h0, 2, ~din, dout);
    check("clamp path", dout[1:0], {~din[0], 1'h0});
    check("clamp pins", pin_val, din);
    u_tester.treset();
    repeat (12) @(negedge i_clk_sys);
    check("reset flags", {test_drive, drv_off}, 2'h0);
    check("reset pins", pin_val, core_val);
    test_done();
  end
endmodule

/* bsi_tap_fsm.sv */
`timescale 1ns/100ps
module bsi_tap_fsm
  import bsi_pkg::*;
(
  input  wire logic i_tck,
  input  wire logic i_trst_n,
  input  wire logic i_tms,
  bsi_tap_if.ctrl   tap
);

  typedef struct packed {
    bsi_tap_state_t st;
  } bsi_fsm_reg_t;

  bsi_fsm_reg_t r;
  bsi_fsm_reg_t next_r;

  // ==========================================================
  // sixteen-state controller
  always_comb begin
    next_r = r;
    case (r.st)
      TAP_TLR:    next_r.st = i_tms ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    next_r.st = i_tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: next_r.st = i_tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_r.st = i_tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  next_r.st = i_tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_r.st = i_tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  next_r.st = i_tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: next_r.st = i_tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_r.st = i_tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: next_r.st = i_tms ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: next_r.st = i_tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  next_r.st = i_tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_r.st = i_tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  next_r.st = i_tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: next_r.st = i_tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_r.st = i_tms ? TAP_SEL_DR : TAP_RTI;
      default:    next_r.st = TAP_TLR;
    endcase
  end

  always_ff @(posedge i_tck) begin
    if (!i_trst_n) begin
      r.st <= TAP_TLR;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // state strobes, valid for the rising edge ending the state
  assign tap.tlr    = (r.st == TAP_TLR);
  assign tap.cap_ir = (r.st == TAP_CAP_IR);
  assign tap.sh_ir  = (r.st == TAP_SH_IR);
  assign tap.upd_ir = (r.st == TAP_UPD_IR);
  assign tap.cap_dr = (r.st == TAP_CAP_DR);
  assign tap.sh_dr  = (r.st == TAP_SH_DR);
  assign tap.upd_dr = (r.st == TAP_UPD_DR);

endmodule

/* bsi_tap_if.sv */
`timescale 1ns/100ps
interface bsi_tap_if;
  logic tlr;
  logic cap_ir;
  logic sh_ir;
  logic upd_ir;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;

  modport ctrl (
    output tlr, cap_ir, sh_ir, upd_ir, cap_dr, sh_dr, upd_dr
  );
  modport core (
    input  tlr, cap_ir, sh_ir, upd_ir, cap_dr, sh_dr, upd_dr
  );
endinterface

/* bsi_tester_model.sv */
`timescale 1ns/100ps
module bsi_tester_model (
  input  wire logic i_clk_sys,
  input  wire logic i_tdo,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  output logic      o_trst_n
);
  initial begin
    o_tck = 1'h0;
    o_tms = 1'h1;
    o_tdi = 1'h0;
    o_trst_n = 1'h0;
  end
  // ====
  // one tck period, tck rests low between frames
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #6 o_tck = 1'h1;
    tdo = i_tdo;
    #6 o_tck = 1'h0;
  endtask

  task automatic treset();
    logic b;
    #1.3;
    o_trst_n = 1'h0;
    tick(1'h1, 1'h0, b);
    tick(1'h1, 1'h0, b);
    o_trst_n = 1'h1;
    tick(1'h0, 1'h1, b);
  endtask

  // idle tdi toggles so a stale bit is never mistaken for data
  task automatic scan(input logic ir, input int n, input logic [162:0] din,
                      output logic [162:0] dout);
    logic b;
    dout = '0;
    @(posedge i_clk_sys);
    #1.3;
    tick(1'h1, ~o_tdi, b);
    if (ir) tick(1'h1, ~o_tdi, b);
    tick(1'h0, ~o_tdi, b);
    tick(1'h0, ~o_tdi, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'h1, ~o_tdi, b);
    tick(1'h0, ~o_tdi, b);
  endtask
endmodule
